// File: aof_host_model.sv
/*
 * Host serial controller model: drives chip select and the serial clock,
 * captures both output lanes. Assumes lanes settle a few core clocks after
 * each shift edge.
 */
`timescale 1ns/10ps
`default_nettype none
module aof_host_model (
	output logic csN,
	output logic sclk,
	input wire logic lane0,
	input wire logic lane1,
	input wire logic oe0N,
	input wire logic oe1N,
	input wire logic rtClk
);
	logic [31:0] cap0;
	logic [31:0] cap1;
	logic [1:0] oeSeen;
	logic rtOn;
	int rises;
	initial
	begin
		csN = 1'b1;
		sclk = 1'b0;
		rtOn = 1'b0;
	end
	// Sampling just before the stepping edge stays clear of the sync delay.
	task automatic grab();
		cap0 = {cap0[30:0], lane0};
		cap1 = {cap1[30:0], lane1};
		oeSeen = {oe1N, oe0N};
	endtask : grab
	always @(posedge rtClk)
	begin
		if (rtOn)
		begin
			#20;
			grab();
			rises++;
		end
	end
	task automatic frame(input logic cpol, input logic cpha, input logic rt, input int nb,
		input int hold);
		cap0 = 32'h0;
		cap1 = 32'h0;
		rises = 0;
		sclk = cpol;
		#83;
		csN = 1'b0;
		rtOn = rt;
		#80;
		if (rt)
			#(hold);
		else
			for (int k = 0; k < nb; k++)
			begin
				sclk = ~cpol;
				#35;
				if (!cpha)
					grab();
				#5;
				sclk = cpol;
				#35;
				if (cpha)
					grab();
				#5;
			end
		rtOn = 1'b0;
		#40;
		csN = 1'b1;
		#100;
	endtask : frame
endmodule : aof_host_model
`default_nettype wire

// File: aof_pkg.sv
/*
 * Constants, field layouts and carrier types for the serial output formatter.
 * Assumes a 32-bit classic Wishbone master and a host that drives chip select
 * and the serial clock.
 */
package aof_pkg;

	localparam logic [5:0] IDX_UNLOCK = 6'h00;
	localparam logic [5:0] IDX_IN_PROTO = 6'h08;
	localparam logic [5:0] IDX_FORMAT = 6'h0c;
	localparam logic [5:0] IDX_RATE = 6'h0d;
	localparam logic [5:0] IDX_SPARE = 6'h0e;
	localparam logic [5:0] IDX_CONTENT = 6'h10;
	localparam logic [5:0] IDX_STATUS = 6'h14;

	localparam logic [7:0] UNLOCK_KEY = 8'haa;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] FMT_WMASK = 8'h77;
	localparam logic [7:0] IN_PROTO_WMASK = 8'h03;
	localparam logic [7:0] RATE_WMASK = 8'h01;
	localparam logic [7:0] CONTENT_WMASK = 8'h30;
	localparam int unsigned CONTENT_LSB = 4;

	localparam logic [1:0] PROTO_RETIMER = 2'h3;
	localparam logic [1:0] CONTENT_RESULT = 2'h0;
	localparam logic [1:0] CONTENT_ID = 2'h1;
	localparam logic [1:0] CONTENT_ID_STS = 2'h2;

	localparam logic [5:0] LEN_RESULT = 6'h10;
	localparam logic [5:0] LEN_ID = 6'h14;
	localparam logic [5:0] LEN_ID_STS = 6'h18;
	localparam logic [5:0] HOST_SHORT = 6'h10;
	localparam logic [5:0] HOST_LONG = 6'h20;

	localparam int unsigned RT_DIV_DEFAULT = 4;

	typedef struct packed {
		logic [15:0] result;
		logic [3:0] chanId;
		logic [3:0] status;
	} aof_sample_t;

	typedef struct packed {
		logic rsvd7;
		logic hostFriendlyFrame;
		logic rightJustify;
		logic laneByteSplit;
		logic rsvd3;
		logic outputLaneCount;
		logic [1:0] outputProtocolSelect;
	} aof_format_t;

endpackage : aof_pkg

// File: aof_serial_out.sv
/*
 * Register file and serial output path of the converter: frame sizing,
 * justification, lane splitting and the standard or re-timer output timing.
 * Assumes csN and sclk come from the host asynchronously; samples arrive on
 * core_clk with a one-cycle load strobe.
 */
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module aof_serial_out #(
	parameter int unsigned RT_DIV = aof_pkg::RT_DIV_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire aof_pkg::aof_sample_t sampleIn,
	input wire logic sampleLoad,
	input wire logic csN,
	input wire logic sclk,
	output logic serialOutLane0,
	output logic lane0OeN,
	output logic serialOutLane1,
	output logic lane1OeN,
	output logic retimerClkOut
);

	if (RT_DIV < 1 || RT_DIV > 255)
	begin : g_bad_div
		$error("RT_DIV must lie between 1 and 255");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} aof_state_t;

	function automatic logic [5:0] natural_len(input logic [1:0] sel);
		case (sel)
			aof_pkg::CONTENT_ID: natural_len = aof_pkg::LEN_ID;
			aof_pkg::CONTENT_ID_STS: natural_len = aof_pkg::LEN_ID_STS;
			default: natural_len = aof_pkg::LEN_RESULT;
		endcase
	endfunction : natural_len

	function automatic logic pick_bit(input logic [31:0] word, input logic [5:0] pos);
		pick_bit = (pos < 6'h20) ? word[5'h1f - pos[4:0]] : 1'b0;
	endfunction : pick_bit

	logic [7:0] unlockReg;
	logic [1:0] inProto;
	aof_pkg::aof_format_t formatReg;
	logic rateBit;
	logic [1:0] contentFmt;
	aof_pkg::aof_sample_t sampleHold;

	// Register bus decode.
	wire [5:0] idx = wb_adr_i[7:2];
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wrEn = req & wb_we_i & wb_sel_i[0];
	wire cfgOpen = (unlockReg == aof_pkg::UNLOCK_KEY);
	wire wrCfg = wrEn & cfgOpen;
	wire [7:0] wrByte = wb_dat_i[7:0];
	wire [7:0] statusByte;
	wire [7:0] readByte =
		(idx == aof_pkg::IDX_UNLOCK) ? unlockReg :
		(idx == aof_pkg::IDX_IN_PROTO) ? {6'h00, inProto} :
		(idx == aof_pkg::IDX_FORMAT) ? (formatReg & aof_pkg::FMT_WMASK) :
		(idx == aof_pkg::IDX_RATE) ? {7'h00, rateBit} :
		(idx == aof_pkg::IDX_CONTENT) ? {2'h0, contentFmt, 4'h0} :
		(idx == aof_pkg::IDX_STATUS) ? statusByte :
		8'h00;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= {24'h00_0000, readByte};
		end
	end

	// Write masks keep reserved positions at zero even if software writes them.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			unlockReg <= aof_pkg::REG_RESET;
			inProto <= 2'h0;
			formatReg <= aof_pkg::REG_RESET;
			rateBit <= 1'b0;
			contentFmt <= 2'h0;
		end
		else
		begin
			if (wrEn && idx == aof_pkg::IDX_UNLOCK)
				unlockReg <= wrByte;
			if (wrCfg && idx == aof_pkg::IDX_IN_PROTO)
				inProto <= wrByte[1:0] & aof_pkg::IN_PROTO_WMASK[1:0];
			if (wrCfg && idx == aof_pkg::IDX_FORMAT)
				formatReg <= wrByte & aof_pkg::FMT_WMASK;
			if (wrCfg && idx == aof_pkg::IDX_RATE)
				rateBit <= wrByte[0] & aof_pkg::RATE_WMASK[0];
			if (wrCfg && idx == aof_pkg::IDX_CONTENT)
				contentFmt <= wrByte[aof_pkg::CONTENT_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sampleHold <= '0;
		else if (sampleLoad)
			sampleHold <= sampleIn;
	end

	// Pin synchronisers; the edge detects compare the second and third stages.
	logic csS1, csS2, csS3, sclkS1, sclkS2, sclkS3;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{csS1, csS2, csS3} <= 3'h7;
			{sclkS1, sclkS2, sclkS3} <= 3'h0;
		end
		else
		begin
			{csS1, csS2, csS3} <= {csN, csS1, csS2};
			{sclkS1, sclkS2, sclkS3} <= {sclk, sclkS1, sclkS2};
		end
	end
	wire csFall = ~csS2 & csS3;
	wire csHigh = csS2;
	wire sclkRise = sclkS2 & ~sclkS3;
	wire sclkFall = ~sclkS2 & sclkS3;

	// Frame assembly from the live configuration, captured at chip select.
	wire [5:0] natLen = natural_len(contentFmt);
	// Bits beyond the natural length must be zero, otherwise a padded frame would leak
	// the channel id or status nibble into what should be fill.
	wire [31:0] natMask = ~(32'hffff_ffff >> natLen);
	wire [31:0] natAligned = {sampleHold, 8'h00} & natMask;
	wire hf = formatReg.hostFriendlyFrame;
	wire twoLane = formatReg.outputLaneCount;
	wire [5:0] hostLen = (natLen <= aof_pkg::HOST_SHORT) ? aof_pkg::HOST_SHORT :
		aof_pkg::HOST_LONG;
	wire [5:0] frameLen = hf ? hostLen : natLen;
	// Right justify shifts the data down behind leading zeros; left keeps trailing zeros.
	wire [5:0] padLen = frameLen - natLen;
	wire [31:0] frameWord = (hf && formatReg.rightJustify) ? (natAligned >> padLen) :
		natAligned;
	wire byteMode = hf & twoLane & formatReg.laneByteSplit;
	wire [5:0] beats = twoLane ? {1'b0, frameLen[5:1]} : frameLen;
	// Codes 01 and 10 are unsupported and fall back to standard timing.
	wire retimerSel = (formatReg.outputProtocolSelect == aof_pkg::PROTO_RETIMER);

	aof_state_t state;
	logic [31:0] shWord;
	logic [5:0] shBeats, shHalf, beat;
	logic shTwo, shByte, shRetimer, shDdr, shCpol, shCpha, primed;
	logic rtClk;
	logic [7:0] rtCnt;

	wire [5:0] idx1 = !shTwo ? beat : (shByte ? beat : {beat[4:0], 1'b0});
	wire [5:0] idx0 = !shTwo ? beat : (shByte ? shHalf + beat : {beat[4:0], 1'b1});
	wire leading = shCpol ? sclkFall : sclkRise;
	wire trailing = shCpol ? sclkRise : sclkFall;
	wire spiEdge = shCpha ? leading : trailing;
	wire rtTick = (state == ST_SHIFT) && shRetimer && (rtCnt == 8'(RT_DIV - 1));
	// SDR advances only as the output clock falls so the host samples on its rise.
	wire rtAdvance = rtTick && (shDdr || rtClk);
	wire advance = shRetimer ? rtAdvance : spiEdge;
	wire lastBeat = (beat + 6'h01 >= shBeats);
	wire active = (state != ST_IDLE);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			shWord <= 32'h0000_0000;
			shBeats <= 6'h00;
			shHalf <= 6'h00;
			beat <= 6'h00;
			{shTwo, shByte, shRetimer, shDdr, shCpol, shCpha, primed} <= 7'h00;
		end
		else if (csHigh)
			state <= ST_IDLE;
		else
			case (state)
				ST_IDLE:
				begin
					if (csFall)
					begin
						state <= ST_SHIFT;
						shWord <= frameWord;
						shBeats <= beats;
						shHalf <= {1'b0, frameLen[5:1]};
						beat <= 6'h00;
						shTwo <= twoLane;
						shByte <= byteMode;
						shRetimer <= retimerSel;
						shDdr <= retimerSel & rateBit;
						{shCpol, shCpha} <= inProto;
						primed <= inProto[0];
					end
				end
				ST_SHIFT:
				begin
					if (advance && primed && !shRetimer)
						primed <= 1'b0;
					else if (advance && lastBeat)
						state <= ST_DONE;
					else if (advance)
						beat <= beat + 6'h01;
				end
				ST_DONE: state <= ST_DONE;
				default: state <= ST_IDLE;
			endcase
	end

	// Re-timer output clock, divided from core_clk and parked low outside frames.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rtClk <= 1'b0;
			rtCnt <= 8'h00;
		end
		else if (state != ST_SHIFT || !shRetimer)
		begin
			rtClk <= 1'b0;
			rtCnt <= 8'h00;
		end
		else if (rtTick)
		begin
			rtClk <= ~rtClk;
			rtCnt <= 8'h00;
		end
		else
			rtCnt <= rtCnt + 8'h01;
	end

	// Both lanes and their enables share one register stage.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serialOutLane0 <= 1'b0;
			serialOutLane1 <= 1'b0;
			lane0OeN <= 1'b1;
			lane1OeN <= 1'b1;
			retimerClkOut <= 1'b0;
		end
		else
		begin
			serialOutLane0 <= (state == ST_SHIFT) & pick_bit(shWord, idx0);
			serialOutLane1 <= (state == ST_SHIFT) & shTwo & pick_bit(shWord, idx1);
			lane0OeN <= ~active;
			lane1OeN <= ~(active & shTwo);
			retimerClkOut <= rtClk;
		end
	end

	assign statusByte = {5'h00, state == ST_DONE, active, cfgOpen};

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_lock_blocks_cfg: assert property (wrEn && idx == aof_pkg::IDX_FORMAT && !cfgOpen
		|=> formatReg == $past(formatReg)) else $error("format written while locked");
	a_key_opens_cfg: assert property (wrEn && idx == aof_pkg::IDX_RATE && cfgOpen
		|=> rateBit == $past(wb_dat_i[0])) else $error("rate not written while open");
	a_spare_reads_zero: assert property ($rose(wb_ack_o) && $past(!wb_we_i
		&& (idx == aof_pkg::IDX_SPARE || idx == aof_pkg::IDX_FORMAT))
		|-> wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[7] == 1'b0 && wb_dat_o[3] == 1'b0
		&& (idx != aof_pkg::IDX_SPARE || wb_dat_o == 32'h0000_0000))
		else $error("reserved bits read nonzero");
	a_plain_length: assert property (state == ST_IDLE && !csHigh && csFall && !hf && !twoLane
		|=> shBeats == $past(natLen)) else $error("plain frame length wrong");
	a_host_length: assert property (state == ST_IDLE && !csHigh && csFall && hf && !twoLane
		|=> shBeats == (($past(natLen) > 6'h10) ? 6'h20 : 6'h10))
		else $error("host frame length wrong");
	a_left_data_first: assert property (state == ST_IDLE && !csHigh && csFall && hf
		&& !formatReg.rightJustify |=> shWord[31:16] == $past(sampleHold.result)
		&& shWord[7:0] == 8'h00 && ($past(natLen) != 6'h10 || shWord[15:0] == 16'h0000))
		else $error("left justified data misplaced");
	a_right_zero_lead: assert property (state == ST_IDLE && !csHigh && csFall && hf
		&& formatReg.rightJustify && natLen == 6'h14 |=> shWord[31:20] == 12'h000
		&& shWord[19:0] == $past(sampleHold[23:4])) else $error("right justify wrong");
	a_justify_ignored: assert property (state == ST_IDLE && !csHigh && csFall && !hf
		|=> shWord == $past(natAligned) && !shByte) else $error("justify used unframed");
	a_interleave_pair: assert property (state == ST_SHIFT && shTwo && !shByte
		|-> idx0 == idx1 + 6'h01) else $error("interleave order wrong");
	a_byte_halves: assert property (state == ST_SHIFT && shTwo && shByte
		|-> idx0 == idx1 + shHalf && (shHalf == 6'h08 || shHalf == 6'h10))
		else $error("byte split wrong");
	a_sdr_no_rise_step: assert property (state == ST_SHIFT && shRetimer && !shDdr && rtTick
		&& !rtClk && !csHigh |=> beat == $past(beat)) else $error("sdr stepped on rise");
	a_std_clock_quiet: assert property (state == ST_SHIFT && !shRetimer
		|=> !retimerClkOut) else $error("re-timer clock in standard mode");
	a_single_lane_off: assert property (active && !shTwo
		|=> lane1OeN && !serialOutLane1) else $error("lane 1 driven in single lane");
	a_dual_lane_on: assert property (active && shTwo
		|=> !lane1OeN) else $error("lane 1 idle in two lane frame");
	a_host_len_two: assert property (state == ST_IDLE && !csHigh && csFall && hf && twoLane
		|=> shBeats == (($past(natLen) > 6'h10) ? 6'h10 : 6'h08))
		else $error("two lane host beats wrong");

	// Register protection: the key alone opens the other configuration registers.
	a_locked_no_proto: assert property (wrEn && idx == aof_pkg::IDX_IN_PROTO && !cfgOpen
		|=> inProto == $past(inProto)) else $error("input mode written locked");
	a_unlock_any_write: assert property (wrEn && idx == aof_pkg::IDX_UNLOCK
		|=> unlockReg == $past(wrByte)) else $error("unlock register not written");

	// Timing selection is frozen at chip select, so these look at the captured copies.
	a_cpha_first_hold: assert property (state == ST_SHIFT && !shRetimer && primed && advance
		&& !csHigh |=> beat == $past(beat) && !primed)
		else $error("first leading edge stepped");
	a_bad_code_std: assert property (state == ST_IDLE && !csHigh && csFall
		&& formatReg.outputProtocolSelect != aof_pkg::PROTO_RETIMER
		|=> !shRetimer) else $error("re-timer chosen for other code");
	a_rate_ignored: assert property (state == ST_IDLE && !csHigh && csFall
		&& !formatReg.outputProtocolSelect[1] |=> !shDdr)
		else $error("data rate used outside re-timer");
	a_ddr_every_tick: assert property (state == ST_SHIFT && shRetimer && shDdr && rtTick
		&& !lastBeat && !csHigh |=> beat == $past(beat) + 6'h01)
		else $error("ddr missed a step");

	c_two_lane_done: cover property (state == ST_SHIFT && shTwo ##1 state == ST_DONE);
	c_retimer_ddr: cover property (state == ST_SHIFT && shRetimer && shDdr && rtAdvance);
	c_host_right: cover property (csFall && state == ST_IDLE && hf && formatReg.rightJustify);
	c_cpha_frame: cover property (state == ST_SHIFT && shCpha && !primed && advance);
	c_byte_split: cover property (state == ST_SHIFT && shByte && advance);

endmodule : aof_serial_out
`default_nettype wire

// File: testbench.sv
/*
 * Bench for the serial output formatter: frame layouts, protocols, locking.
 * Assumes the host model as link partner and a one-cycle Wishbone answer.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0] fmt;
		logic [1:0] cont;
		logic [1:0] spi;
		logic rate;
		aof_pkg::aof_sample_t smp;
	} aof_case_t;
	logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sampleLoad, csN, sclk;
	logic [7:0] wb_adr_i;
	logic [7:0] rd;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	aof_pkg::aof_sample_t sampleIn;
	logic serialOutLane0, lane0OeN, serialOutLane1, lane1OeN, retimerClkOut;
	int n_fail, n_compared, sdrRises;
	aof_case_t cases [16];
	aof_serial_out #(.RT_DIV(4)) dut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sampleIn, .sampleLoad, .csN,
		.sclk, .serialOutLane0, .lane0OeN, .serialOutLane1, .lane1OeN, .retimerClkOut);
	aof_host_model host (.csN, .sclk, .lane0(serialOutLane0), .lane1(serialOutLane1),
		.oe0N(lane0OeN), .oe1N(lane1OeN), .rtClk(retimerClkOut));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic conclude();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] d);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= {24'h0, d};
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (wb_ack_o !== 1'b1 && i < 40);
		if (wb_ack_o !== 1'b1)
		begin
			n_fail++;
			conclude();
		end
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask : xfer
	task automatic expFrame(input aof_case_t c, output logic [31:0] e0,
		output logic [31:0] e1, output int nb);
		aof_pkg::aof_format_t f;
		logic [31:0] fw;
		int n, l;
		f = c.fmt;
		n = 16 + 4 * c.cont;
		fw = {c.smp, 8'h00} & ~(32'hffffffff >> n);
		l = n;
		if (f.hostFriendlyFrame)
		begin
			l = (n <= 16) ? 16 : 32;
			if (f.rightJustify)
				fw = fw >> (l - n);
		end
		nb = f.outputLaneCount ? l / 2 : l;
		e0 = 32'h0;
		e1 = 32'h0;
		for (int k = 0; k < nb; k++)
			if (!f.outputLaneCount)
				e0 = {e0[30:0], fw[31 - k]};
			else if (f.hostFriendlyFrame && f.laneByteSplit)
			begin
				e1 = {e1[30:0], fw[31 - k]};
				e0 = {e0[30:0], fw[31 - nb - k]};
			end
			else
			begin
				e1 = {e1[30:0], fw[31 - 2 * k]};
				e0 = {e0[30:0], fw[30 - 2 * k]};
			end
	endtask : expFrame
	initial
	begin
		#1000000;
		n_fail++;
		conclude();
	end
	initial
	begin
		aof_case_t c;
		logic [31:0] e0, e1;
		int nb;
		logic rt;
		cases = '{
			'{8'h00, 2'h0, 2'h0, 1'h1, 24'ha5c396},
			'{8'h00, 2'h1, 2'h1, 1'h0, 24'h3c5a71},
			'{8'h00, 2'h2, 2'h2, 1'h0, 24'hf00f9e},
			'{8'h20, 2'h2, 2'h3, 1'h0, 24'h81e7c4},
			'{8'h40, 2'h0, 2'h0, 1'h0, 24'h6d2b53},
			'{8'h40, 2'h1, 2'h1, 1'h0, 24'hc91e28},
			'{8'h60, 2'h2, 2'h0, 1'h0, 24'h5ae1b7},
			'{8'h60, 2'h0, 2'h3, 1'h0, 24'h1248f3},
			'{8'h04, 2'h1, 2'h0, 1'h0, 24'hb6d30c},
			'{8'h14, 2'h2, 2'h2, 1'h0, 24'h7e81a5},
			'{8'h54, 2'h0, 2'h0, 1'h0, 24'h9c3f60},
			'{8'h74, 2'h1, 2'h1, 1'h0, 24'h2d95ea},
			'{8'h44, 2'h2, 2'h0, 1'h0, 24'he4172b},
			'{8'h50, 2'h2, 2'h0, 1'h0, 24'h4bc81d},
			'{8'h03, 2'h1, 2'h0, 1'h0, 24'h8f3e56},
			'{8'h03, 2'h1, 2'h0, 1'h1, 24'h8f3e56}};
		{wb_cyc_i, wb_stb_i, wb_we_i, sampleLoad} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		sampleIn = 24'h0;
		rst_n = 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		xfer(1'b1, aof_pkg::IDX_UNLOCK, aof_pkg::UNLOCK_KEY);
		foreach (cases[i])
		begin
			c = cases[i];
			xfer(1'b1, aof_pkg::IDX_IN_PROTO, {6'h00, c.spi});
			xfer(1'b1, aof_pkg::IDX_FORMAT, c.fmt);
			xfer(1'b1, aof_pkg::IDX_RATE, {7'h00, c.rate});
			xfer(1'b1, aof_pkg::IDX_CONTENT, {2'h0, c.cont, 4'h0});
			xfer(1'b0, aof_pkg::IDX_FORMAT, 8'h00);
			check({24'h0, rd}, {24'h0, c.fmt});
			sampleIn <= c.smp;
			sampleLoad <= 1'b1;
			@(posedge core_clk);
			sampleLoad <= 1'b0;
			expFrame(c, e0, e1, nb);
			rt = (c.fmt[1:0] == aof_pkg::PROTO_RETIMER);
			host.frame(c.spi[1], c.spi[0], rt, nb, nb * 80 + 200);
			if (rt && c.rate)
				check({31'h0, host.rises < sdrRises}, 32'h1);
			else
			begin
				check(host.cap0, e0);
				check(host.cap1, e1);
				check({30'h0, host.oeSeen}, {30'h0, !c.fmt[2], 1'b0});
			end
			sdrRises = host.rises;
			@(posedge core_clk);
		end
		rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		xfer(1'b0, aof_pkg::IDX_RATE, 8'h00);
		check({24'h0, rd}, 32'h0);
		xfer(1'b0, aof_pkg::IDX_SPARE, 8'h00);
		check({24'h0, rd}, 32'h0);
		xfer(1'b1, aof_pkg::IDX_FORMAT, 8'h44);
		xfer(1'b0, aof_pkg::IDX_FORMAT, 8'h00);
		check({24'h0, rd}, 32'h0);
		xfer(1'b1, aof_pkg::IDX_UNLOCK, 8'hab);
		xfer(1'b1, aof_pkg::IDX_RATE, 8'h01);
		xfer(1'b0, aof_pkg::IDX_RATE, 8'h00);
		check({24'h0, rd}, 32'h0);
		xfer(1'b1, aof_pkg::IDX_UNLOCK, 8'haa);
		xfer(1'b1, aof_pkg::IDX_RATE, 8'h01);
		xfer(1'b0, aof_pkg::IDX_RATE, 8'h00);
		check({24'h0, rd}, 32'h1);
		xfer(1'b0, aof_pkg::IDX_STATUS, 8'h00);
		check({24'h0, rd}, 32'h1);
		xfer(1'b0, 6'h3f, 8'h00);
		check({24'h0, rd}, 32'h0);
		conclude();
	end
endmodule : testbench
`default_nettype wire
